// *** hdl/vmar_pkg.sv ***
// Summary of operation
// [RULE1] row-scan-select low: address bit 14 becomes row scan bit 1.
// [RULE2] compatibility-support low: address bit 13 becomes row scan bit 0.
// [RULE3] a substitution control bit high passes its reordered bit unchanged.
// [RULE4] substitution follows reordering, just before the decoder input.
// [RULE5] byte mode: each reordered bit n equals counter bit n.
// [RULE6] word mode: outputs 1..15 take counter 0..14; output 0 takes 15 or 13.
// [RULE7] doubleword mode: output 0 takes 12, 1 takes 13, 2..15 take 0..13.
`default_nettype none
package vmar_pkg;

   localparam int ADDR_W        = 16;
   localparam int RS_W          = 2;
   localparam int SUB_HI_POS    = 14;
   localparam int SUB_LO_POS    = 13;
   localparam int RS_HI_POS     = 1;
   localparam int RS_LO_POS     = 0;
   localparam int WORD_WRAP_SRC = 15;
   localparam int WORD_CGA_SRC  = 13;
   localparam int DW_OUT0_SRC   = 12;
   localparam int DW_OUT1_SRC   = 13;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

   typedef enum logic [2:0] {
      VMAR_BYTE  = 3'b001,
      VMAR_WORD  = 3'b010,
      VMAR_DWORD = 3'b100
   } vmar_mode_e;

   // cleared control bits decode to word mode
   localparam vmar_mode_e MODE_RST = VMAR_WORD;

   typedef struct packed {
      logic dword_sel;
      logic byte_word_sel;
      logic wrap_sel;
      logic row_scan_sel;
      logic compat_sel;
   } vmar_ctrl_s;

endpackage
`default_nettype wire

// *** hdl/vmar_reorder.sv ***
`timescale 1ns/100ps
`default_nettype none
module vmar_reorder (
   // mode
   input  wire vmar_pkg::vmar_mode_e           mode,
   input  wire logic                           wrap_sel,
   // address
   input  wire logic [vmar_pkg::ADDR_W-1:0]    counter_addr,
   output logic      [vmar_pkg::ADDR_W-1:0]    reordered_address_bit
);

   always_comb begin
      unique case (mode)
         vmar_pkg::VMAR_BYTE: begin
            reordered_address_bit = counter_addr; // [RULE5]
         end
         vmar_pkg::VMAR_WORD: begin
            reordered_address_bit = {counter_addr[vmar_pkg::ADDR_W-2:0], // [RULE6]
                                     wrap_sel ? counter_addr[vmar_pkg::WORD_WRAP_SRC]
                                              : counter_addr[vmar_pkg::WORD_CGA_SRC]};
         end
         vmar_pkg::VMAR_DWORD: begin
            reordered_address_bit = {counter_addr[vmar_pkg::ADDR_W-3:0], // [RULE7]
                                     counter_addr[vmar_pkg::DW_OUT1_SRC],
                                     counter_addr[vmar_pkg::DW_OUT0_SRC]};
         end
         default: begin
            reordered_address_bit = counter_addr;
         end
      endcase
   end

endmodule
`default_nettype wire

// *** hdl/vmar_remap.sv ***
`timescale 1ns/100ps
`default_nettype none
module vmar_remap (
   // clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           rst_n,
   // mode control bits
   input  wire vmar_pkg::vmar_ctrl_s           ctrl,
   // counters
   input  wire logic [vmar_pkg::ADDR_W-1:0]    counter_addr,
   input  wire logic [vmar_pkg::RS_W-1:0]      row_scan_bit,
   // decoder side
   output logic      [vmar_pkg::ADDR_W-1:0]    decoder_input_bit,
   output logic      [2:0]                     mode_state
);

   // mode decode
   vmar_pkg::vmar_mode_e              mode;
   vmar_pkg::vmar_mode_e              mode_next;
   vmar_pkg::vmar_mode_e              mode_reg;

   // address path
   logic [vmar_pkg::ADDR_W-1:0]       reordered;
   wire logic [vmar_pkg::ADDR_W-1:0]  sub_enable;
   wire logic [vmar_pkg::ADDR_W-1:0]  sub_source;
   wire logic [vmar_pkg::ADDR_W-1:0]  substituted;
   logic [vmar_pkg::ADDR_W-1:0]       decoder_input_next;
   logic [vmar_pkg::ADDR_W-1:0]       decoder_input_reg;

   // substitution controls
   logic                              sub_hi_en;
   logic                              sub_lo_en;
   logic                              rs_hi;
   logic                              rs_lo;

   // doubleword bit dominates the byte/word select
   always_comb begin
      if (ctrl.dword_sel) begin
         mode = vmar_pkg::VMAR_DWORD; // [RULE7]
      end else if (ctrl.byte_word_sel) begin
         mode = vmar_pkg::VMAR_BYTE; // [RULE5]
      end else begin
         mode = vmar_pkg::VMAR_WORD; // [RULE6]
      end
   end

   vmar_reorder u_reorder (
      .mode                  (mode),
      .wrap_sel              (ctrl.wrap_sel),
      .counter_addr          (counter_addr),
      .reordered_address_bit (reordered)
   );

   // a low control bit selects the row scan bit
   always_comb begin
      sub_hi_en = !ctrl.row_scan_sel; // [RULE1]
      sub_lo_en = !ctrl.compat_sel; // [RULE2]
      rs_hi     = row_scan_bit[vmar_pkg::RS_HI_POS];
      rs_lo     = row_scan_bit[vmar_pkg::RS_LO_POS];
   end

   // substitution works on the reordered word only
   for (genvar b = 0; b < vmar_pkg::ADDR_W; b++) begin : g_bit
      if (b == vmar_pkg::SUB_HI_POS) begin : g_hi
         assign sub_enable[b] = sub_hi_en; // [RULE1]
         assign sub_source[b] = rs_hi;
      end else if (b == vmar_pkg::SUB_LO_POS) begin : g_lo
         assign sub_enable[b] = sub_lo_en; // [RULE2]
         assign sub_source[b] = rs_lo;
      end else begin : g_pass
         assign sub_enable[b] = 1'b0;
         assign sub_source[b] = reordered[b];
      end
      assign substituted[b] = sub_enable[b] ? sub_source[b] : reordered[b]; // [RULE3] [RULE4]
   end

   always_comb begin
      decoder_input_next = substituted; // [RULE4]
      mode_next          = mode;
   end

   // registered so the decoder sees a glitch-free address
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         decoder_input_reg <= vmar_pkg::ADDR_RST;
      end else begin
         decoder_input_reg <= decoder_input_next; // [RULE4]
      end
   end

   // mode reported in step with the address it produced
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_reg <= vmar_pkg::MODE_RST;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign decoder_input_bit = decoder_input_reg;
   assign mode_state        = mode_reg;

endmodule
`default_nettype wire

// *** verif/vmar_scan_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module vmar_scan_model (
   // row scan counter
   input  wire logic   core_clk,
   output logic [1:0]  row_scan_bit = 2'h0
);
   // steps every clock so both row scan bits keep moving
   always @(posedge core_clk) row_scan_bit <= row_scan_bit + 2'h1;
endmodule
`default_nettype wire

// *** verif/vmar_remap_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module vmar_remap_asserts (
   // watched ports
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   input wire vmar_pkg::vmar_ctrl_s ctrl,
   input wire logic [15:0]          counter_addr,
   input wire logic [1:0]           row_scan_bit,
   input wire logic [15:0]          decoder_input_bit,
   input wire logic [2:0]           mode_state
);
   logic [4:0]  c;
   logic [15:0] a;
   logic [1:0]  r;
   logic        v = 1'b0;
   wire  [15:0] d = decoder_input_bit;
   // inputs as the output register took them
   always_ff @(posedge core_clk) {v, c, a, r} <= {rst_n, ctrl, counter_addr, row_scan_bit};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!v);
   a_row_hi:
      assert property (!c[1] |-> d[14] == r[1]) else $error("bit 14 not from row scan");
   a_row_lo:
      assert property (!c[0] |-> d[13] == r[0]) else $error("bit 13 not from row scan");
   a_no_sub:
      assert property (c == 5'h0b |-> d[14:13] == a[14:13]) else $error("bits 14:13 altered");
   a_sub_last:
      assert property (c == 5'h10 |-> d == {a[13], r, a[10:0], a[13:12]}) else $error("substitution before reorder");
   a_byte_map:
      assert property (c[4:3] == 2'h1 && c[1:0] == 2'h3 |-> d == a) else $error("byte map");
   a_word_map:
      assert property (c[4:3] == 2'h0 && c[1:0] == 2'h3 |-> d == {a[14:0], c[2] ? a[15] : a[13]}) else $error("word map");
   a_dword_map:
      assert property (c[4] && c[1:0] == 2'h3 |-> d == {a[13:0], a[13:12]}) else $error("dword map");
   a_mode_code:
      assert property (mode_state == (c[4] ? vmar_pkg::VMAR_DWORD : c[3] ? vmar_pkg::VMAR_BYTE : vmar_pkg::VMAR_WORD))
         else $error("mode code");
   a_rst_clear:
      assert property (disable iff (1'b0) !rst_n |=> d == vmar_pkg::ADDR_RST && mode_state == vmar_pkg::MODE_RST)
         else $error("reset value");
   cover property (c == 5'h10);
   cover property (c[4:2] == 3'h0);
   cover property (c == 5'h0b);
   cover property (!rst_n);
endmodule
bind vmar_remap vmar_remap_asserts u_chk (
   .core_clk          (core_clk),
   .rst_n             (rst_n),
   .ctrl              (ctrl),
   .counter_addr      (counter_addr),
   .row_scan_bit      (row_scan_bit),
   .decoder_input_bit (decoder_input_bit),
   .mode_state        (mode_state)
);
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                 core_clk = 1'b0;
   logic                 rst_n = 1'b0;
   vmar_pkg::vmar_ctrl_s c = '0;
   logic [15:0]          a = 16'h0000;
   logic [15:0]          q;
   logic [2:0]           m;
   logic [15:0]          e;
   logic [2:0]           em;
   logic [1:0]           r;
   int                   failures = 0;
   int                   check_count = 0;
   int                   n = 0;
   vmar_remap DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrl(c), .counter_addr(a), .row_scan_bit(r),
                   .decoder_input_bit(q), .mode_state(m));
   vmar_scan_model u_scan (.core_clk(core_clk), .row_scan_bit(r));
   always #10 core_clk = ~core_clk;
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] s, logic [15:0] x);
      check_count++;
      if (s !== x) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, x, s);
      end
   endtask
   function automatic logic [2:0] g(logic [4:0] x);
      return x[4] ? vmar_pkg::VMAR_DWORD : x[3] ? vmar_pkg::VMAR_BYTE : vmar_pkg::VMAR_WORD;
   endfunction
   function automatic logic [15:0] f(logic [4:0] x, logic [15:0] y, logic [1:0] z);
      logic [15:0] m;
      m = x[4] ? {y[13:0], y[13:12]} : x[3] ? y : {y[14:0], x[2] ? y[15] : y[13]};
      m[14] = x[1] ? m[14] : z[1];
      m[13] = x[0] ? m[13] : z[0];
      return m;
   endfunction
   always @(posedge core_clk) begin
      if (++n == 500) begin
         failures++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      chk("decoder_input_bit", q, vmar_pkg::ADDR_RST);
      chk("mode_state", {13'h0, m}, {13'h0, vmar_pkg::MODE_RST});
      @(posedge core_clk) rst_n <= 1'b1;
      // each control code held four cycles so the row scan bits take every value under it
      for (int i = 0; i < 130; i++) begin
         @(posedge core_clk);
         e = f(c, a, r);
         em = g(c);
         c <= i[6:2];
         a <= 16'(i * 16'h9e37);
         @(negedge core_clk);
         chk("decoder_input_bit", q, e);
         chk("mode_state", {13'h0, m}, {13'h0, em});
      end
      // reset in mid-run returns both outputs to their reset values, the first edge after it remaps again
      @(posedge core_clk) rst_n <= 1'b0;
      @(posedge core_clk) rst_n <= 1'b1;
      @(negedge core_clk);
      chk("decoder_input_bit", q, vmar_pkg::ADDR_RST);
      chk("mode_state", {13'h0, m}, {13'h0, vmar_pkg::MODE_RST});
      @(posedge core_clk);
      e = f(c, a, r);
      em = g(c);
      @(negedge core_clk);
      chk("decoder_input_bit", q, e);
      chk("mode_state", {13'h0, m}, {13'h0, em});
      tally_and_finish;
   end
endmodule
`default_nettype wire
